// *** rtl/csc_pkg.sv ***
// Shared constants and types of the conversion and sleep controller
package csc_pkg;
  localparam int          CNT_W          = 11;
  // Conversion and calibration lengths in clock cycles (plain defaults)
  localparam logic [10:0] CONV_CYCLES    = 11'h040;
  localparam logic [10:0] CAL_CYCLES     = 11'h400;
  localparam logic [10:0] CNT_ONE        = 11'h001;
  localparam logic [10:0] CNT_ZERO       = 11'h000;
  // Reset values of the sampled trigger levels (both idle high)
  localparam logic        CONV_PREV_RST  = 1'h1;
  localparam logic        CAL_PREV_RST   = 1'h1;

  typedef enum logic [1:0] {
    CSC_IDLE,
    CSC_CONVERT,
    CSC_CALIBRATE,
    CSC_SLEEP
  } csc_state_t;
endpackage : csc_pkg

// *** rtl/csc_ev_if.sv ***
// Event carrier from the trigger edge detector to the controller
`timescale 1ns/10ps
`default_nettype none
interface csc_ev_if;
  logic conv_rise;
  logic cal_rise;
  logic cal_low;

  modport src (output conv_rise, output cal_rise, output cal_low);
  modport dst (input conv_rise, input cal_rise, input cal_low);
endinterface : csc_ev_if
`default_nettype wire

// *** rtl/csc_edge.sv ***
// Edge detector for the conversion and calibration trigger inputs
`timescale 1ns/10ps
`default_nettype none
module csc_edge
  import csc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_conversion_trigger,
  input  wire logic i_cal_trigger_n,
  csc_ev_if.src     ev
);
  logic conv_prev_q;
  logic cal_prev_q;

  // Idle-high reset values keep a trigger held high from looking like a new edge
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      conv_prev_q <= CONV_PREV_RST;
      cal_prev_q  <= CAL_PREV_RST;
    end else begin
      conv_prev_q <= i_conversion_trigger;
      cal_prev_q  <= i_cal_trigger_n;
    end
  end

  assign ev.conv_rise = i_conversion_trigger & ~conv_prev_q;
  assign ev.cal_rise  = i_cal_trigger_n & ~cal_prev_q;
  assign ev.cal_low   = ~i_cal_trigger_n;
endmodule : csc_edge
`default_nettype wire

// *** rtl/csc_top.sv ***
// Conversion, calibration and sleep controller of the serial converter
`timescale 1ns/10ps
`default_nettype none
module csc_top
  import csc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_conversion_trigger,
  input  wire logic i_cal_trigger_n,
  input  wire logic i_sleep_n,
  output logic      o_busy,
  output logic      o_hold,
  output logic      o_power_down,
  output logic      o_cal_valid
);
  // Trigger edges reach the controller through the event carrier
  csc_ev_if ev ();

  csc_state_t       state_q;
  csc_state_t       state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             busy_q;
  logic             hold_q;
  logic             power_down_q;
  logic             cal_valid_q;
  logic             op_done;
  // Decoded strobes of the current cycle
  logic             cal_clear;
  logic             cal_done;
  logic             conv_go;
  logic             sleep_go;
  // Next values of the output flops
  logic             busy_d;
  logic             hold_d;
  logic             power_down_d;
  logic             cal_valid_d;

  csc_edge u_edge (
    .i_clk                (i_clk),
    .i_reset_n            (i_reset_n),
    .i_conversion_trigger (i_conversion_trigger),
    .i_cal_trigger_n      (i_cal_trigger_n),
    .ev                   (ev)
  );

  // State decoding shared by the output flops and the calibration flag
  function automatic logic state_busy(input csc_state_t s);
    state_busy = (s == CSC_CONVERT) || (s == CSC_CALIBRATE);
  endfunction : state_busy

  function automatic logic state_hold(input csc_state_t s);
    state_hold = (s == CSC_CONVERT);
  endfunction : state_hold

  function automatic logic state_asleep(input csc_state_t s);
    state_asleep = (s == CSC_SLEEP);
  endfunction : state_asleep

  function automatic logic state_cal(input csc_state_t s);
    state_cal = (s == CSC_CALIBRATE);
  endfunction : state_cal

  assign op_done   = (cnt_q == CNT_ZERO);
  // Calibration input low or its fresh rise both invalidate the stored result
  assign cal_clear = ev.cal_low | ev.cal_rise;
  // Completion comes from the current state so an aborted run never marks a result
  assign cal_done  = state_cal(state_q) & op_done;
  // A conversion start needs an idle engine and an awake host
  assign conv_go   = (state_q == CSC_IDLE) & i_sleep_n & ev.conv_rise;
  // Sleep is honoured only once nothing runs, which defers it behind busy
  assign sleep_go  = (state_q == CSC_IDLE) & ~i_sleep_n;

  // Next state; the calibration input outranks every other operation
  always_comb begin
    state_d = state_q;
    if (ev.cal_low) begin
      // Held calibration input overrides everything, including a running conversion
      state_d = CSC_IDLE;
    end else if (ev.cal_rise) begin
      state_d = CSC_CALIBRATE;
    end else begin
      case (state_q)
        CSC_IDLE: begin
          if (sleep_go) begin
            state_d = CSC_SLEEP;
          end else if (conv_go) begin
            state_d = CSC_CONVERT;
          end
        end
        CSC_CONVERT: begin
          // Further conversion trigger edges are ignored until the conversion ends
          if (op_done) begin
            state_d = CSC_IDLE;
          end
        end
        CSC_CALIBRATE: begin
          if (op_done) begin
            state_d = CSC_IDLE;
          end
        end
        CSC_SLEEP: begin
          // Conversion edges seen while asleep are dropped, not queued
          if (i_sleep_n) begin
            state_d = CSC_IDLE;
          end
        end
        default: begin
          state_d = CSC_IDLE;
        end
      endcase
    end
  end

  // Cycle count of the running operation, loaded on entry and stepped to zero
  always_comb begin
    cnt_d = cnt_q;
    if (ev.cal_low) begin
      cnt_d = CNT_ZERO;
    end else if (ev.cal_rise) begin
      // A fresh calibration rise restarts the run from the top
      cnt_d = CAL_CYCLES - CNT_ONE;
    end else begin
      case (state_q)
        CSC_IDLE: begin
          if (!sleep_go && conv_go) begin
            cnt_d = CONV_CYCLES - CNT_ONE;
          end
        end
        CSC_CONVERT, CSC_CALIBRATE: begin
          if (!op_done) begin
            cnt_d = cnt_q - CNT_ONE;
          end
        end
        CSC_SLEEP: begin
          cnt_d = CNT_ZERO;
        end
        default: begin
          cnt_d = CNT_ZERO;
        end
      endcase
    end
  end

  // State and count registers
  // The count width covers the longest run; a longer calibration needs CNT_W widened
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= CSC_IDLE;
      cnt_q   <= CNT_ZERO;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Outputs are registered from the next state so they move with the state itself
  assign busy_d       = state_busy(state_d);
  assign hold_d       = state_hold(state_d);
  assign power_down_d = state_asleep(state_d);

  // Calibration result survives sleep; only the calibration input clears it
  always_comb begin
    cal_valid_d = cal_valid_q;
    if (cal_clear) begin
      cal_valid_d = 1'h0;
    end else if (cal_done) begin
      cal_valid_d = 1'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy_q <= 1'h0;
    end else begin
      busy_q <= busy_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hold_q <= 1'h0;
    end else begin
      hold_q <= hold_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      power_down_q <= 1'h0;
    end else begin
      power_down_q <= power_down_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cal_valid_q <= 1'h0;
    end else begin
      cal_valid_q <= cal_valid_d;
    end
  end

  // Ports are driven straight from the flops above
  assign o_busy       = busy_q;
  assign o_hold       = hold_q;
  assign o_power_down = power_down_q;
  assign o_cal_valid  = cal_valid_q;
endmodule : csc_top
`default_nettype wire

// *** bench/csc_monitor.sv ***
// Port checker of the conversion and sleep controller
`timescale 1ns/10ps
`default_nettype none
module csc_monitor
  import csc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_conversion_trigger,
  input wire logic i_cal_trigger_n,
  input wire logic i_sleep_n,
  input wire logic o_busy,
  input wire logic o_hold,
  input wire logic o_power_down,
  input wire logic o_cal_valid
);
  logic [10:0] hcnt_q;
  logic [10:0] bcnt_q;
  // Run lengths exceed any unrolled repetition, so they are counted
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n) hcnt_q <= CNT_ZERO;
    else hcnt_q <= o_hold ? hcnt_q + CNT_ONE : CNT_ZERO;
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n) bcnt_q <= CNT_ZERO;
    else bcnt_q <= o_busy ? bcnt_q + CNT_ONE : CNT_ZERO;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence cal_go; $rose(i_cal_trigger_n); endsequence
  sequence cal_run; o_busy && !o_cal_valid; endsequence
  hold_start_a: assert property ($rose(i_conversion_trigger) && !o_busy && !o_power_down
    && i_sleep_n && i_cal_trigger_n && $past(i_cal_trigger_n) |=> o_hold && o_busy)
    else $error("conversion did not start");
  conv_end_a: assert property ($fell(o_hold) && $past(i_cal_trigger_n)
    |-> hcnt_q == CONV_CYCLES && !o_busy) else $error("bad conversion length");
  cal_start_a: assert property (cal_go |=> cal_run) else $error("no calibration");
  cal_end_a: assert property ($rose(o_cal_valid) |-> bcnt_q == CAL_CYCLES && !o_busy)
    else $error("bad calibration length");
  sleep_enter_a: assert property (!i_sleep_n && !o_busy && i_cal_trigger_n
    && $past(i_cal_trigger_n) |=> o_power_down) else $error("no power-down");
  sleep_leave_a: assert property (i_sleep_n |=> !o_power_down) else $error("stuck asleep");
  cal_reset_a: assert property (!i_cal_trigger_n |=> !o_busy && !o_hold
    && !o_cal_valid && !o_power_down) else $error("calibration reset ignored");
  sleep_defer_a: assert property (o_busy |-> !o_power_down) else $error("slept while busy");
endmodule : csc_monitor
`default_nettype wire

// *** bench/csc_host.sv ***
// Host model driving the trigger, calibration and sleep inputs
`timescale 1ns/10ps
`default_nettype none
module csc_host (
  input  wire logic i_clk,
  output logic      o_conv,
  output logic      o_cal_n,
  output logic      o_sleep_n
);
  // Trigger rests high between requests
  initial {o_conv, o_cal_n, o_sleep_n} = 3'h7;
  task automatic pulse(input bit cal);
    @(posedge i_clk) #1;
    if (cal) o_cal_n = 1'h0;
    else o_conv = 1'h0;
    @(posedge i_clk) #1;
    o_cal_n = 1'h1;
    o_conv = 1'h1;
  endtask : pulse
  task automatic nap(input logic v);
    @(posedge i_clk) #1;
    o_sleep_n = v;
  endtask : nap
endmodule : csc_host
`default_nettype wire

// *** bench/csc_top_tb_top.sv ***
// Self-checking bench of the conversion and sleep controller
`timescale 1ns/10ps
`default_nettype none
module csc_top_tb_top
  import csc_pkg::*;
;
  logic i_clk = 1'h0;
  logic i_reset_n = 1'h0;
  logic i_conversion_trigger, i_cal_trigger_n, i_sleep_n;
  logic o_busy, o_hold, o_power_down, o_cal_valid;
  logic [10:0] q[$];
  logic [10:0] blen = CNT_ZERO;
  int failures = 0, checked = 0, cyc = 0;
  always #4 i_clk = ~i_clk;
  csc_top i_dut (.*);
  csc_host i_host (.i_clk(i_clk), .o_conv(i_conversion_trigger),
    .o_cal_n(i_cal_trigger_n), .o_sleep_n(i_sleep_n));
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("Counts: %0d checked, %0d failed", checked, failures);
    if (failures == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic idle();
    repeat (2) @(negedge i_clk);
    while (o_busy !== 1'h0) @(negedge i_clk);
  endtask : idle
  always @(posedge i_clk) if (++cyc == 5000) begin
    failures++;
    test_done();
  end
  // Busy run lengths are matched against the oldest note
  always @(negedge i_clk) if (o_busy === 1'h1) blen++;
  else if (blen != CNT_ZERO) begin
    check(blen, q.pop_front());
    blen = CNT_ZERO;
  end
  initial begin
    void'($urandom(41));
    repeat (5) @(posedge i_clk);
    #1 i_reset_n = 1'h1;
    for (int n = 0; n < 3; n++) begin
      repeat ($urandom_range(1, 9)) @(posedge i_clk);
      q.push_back(CONV_CYCLES);
      // On the last round a second trigger lands inside the conversion and is ignored
      for (int k = 0; k <= (n == 2); k++) begin
        i_host.pulse(0);
        repeat ($urandom_range(2, 50)) @(posedge i_clk);
      end
      idle();
    end
    $display("test conversion done");
    q.push_back(CAL_CYCLES);
    i_host.pulse(1);
    idle();
    check(o_cal_valid, 1'h1);
    $display("test calibration done");
    q.push_back(CONV_CYCLES);
    i_host.pulse(0);
    i_host.nap(!i_sleep_n);
    idle();
    @(negedge i_clk);
    check(o_power_down, 1'h1);
    check(o_cal_valid, 1'h1);
    i_host.pulse(0);
    idle();
    check(o_busy, 1'h0);
    i_host.nap(!i_sleep_n);
    // Sleep input is sampled at the next rising edge, so look after it
    repeat (2) @(negedge i_clk);
    check(o_power_down, 1'h0);
    q.push_back(CONV_CYCLES);
    i_host.pulse(0);
    idle();
    $display("test sleep done");
    test_done();
  end
endmodule : csc_top_tb_top
bind csc_top csc_monitor i_mon (.*);
`default_nettype wire
